// *** hdl/fws_status_bank.sv ***
// Operation
// - channel fault word bits 7 and 6 show overcurrent on channels 1 and 2
// - channel fault word bits 3 and 2 show offset faults on channels 1 and 2
// - first global word bit 4 shows an invalid input clock
// - first global word bits 3 and 2 show power-stage and battery overvoltage
// - first global word bits 1 and 0 show power-stage and battery undervoltage
// - second global word bit 4 shows device-wide thermal shutdown
// - second global word bits 3 and 2 show per-channel thermal shutdown
// - warning word bit 5 shows that a logic power-on reset happened
// - warning word bit 4 shows device-wide thermal warning
// - warning word bits 3 and 2 show per-channel thermal warnings
// - channel and both global fault words read zero after reset
// - warning word reads 0x20 after reset
// - fault pin reports unmasked overcurrent, shutdown, voltage and offset faults
// - warning pin reports unmasked thermal warnings
`timescale 1ns/1ps
`include "fws_cfg.svh"

module fws_status_bank (
   input wire logic clock,
   input wire logic reset,
   input wire logic chan1_overcurrent_flag,
   input wire logic chan2_overcurrent_flag,
   input wire logic chan1_offset_fault_flag,
   input wire logic chan2_offset_fault_flag,
   input wire logic invalid_clock_flag,
   input wire logic power_stage_overvoltage_flag,
   input wire logic battery_overvoltage_flag,
   input wire logic power_stage_undervoltage_flag,
   input wire logic battery_undervoltage_flag,
   input wire logic global_thermal_shutdown_flag,
   input wire logic chan1_thermal_shutdown_flag,
   input wire logic chan2_thermal_shutdown_flag,
   input wire logic global_thermal_warning_flag,
   input wire logic chan1_thermal_warning_flag,
   input wire logic chan2_thermal_warning_flag,
   input wire logic por_clear,
   input wire logic reg_sel,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output fws_pkg::fws_byte_t reg_rdata,
   output logic reg_ack,
   output logic fault_pin,
   output logic warn_pin
);

   // -----------------------------------------------------------------
   // detector capture
   // -----------------------------------------------------------------
   fws_pkg::fws_flags_t det_raw;
   fws_pkg::fws_flags_t det_s;

   // gather detector lines into one vector
   always_comb begin
      det_raw = '0;
      det_raw[`FWS_I_CH1_OVC] = chan1_overcurrent_flag;
      det_raw[`FWS_I_CH2_OVC] = chan2_overcurrent_flag;
      det_raw[`FWS_I_CH1_OFS] = chan1_offset_fault_flag;
      det_raw[`FWS_I_CH2_OFS] = chan2_offset_fault_flag;
      det_raw[`FWS_I_CLK] = invalid_clock_flag;
      det_raw[`FWS_I_PS_OV] = power_stage_overvoltage_flag;
      det_raw[`FWS_I_BAT_OV] = battery_overvoltage_flag;
      det_raw[`FWS_I_PS_UV] = power_stage_undervoltage_flag;
      det_raw[`FWS_I_BAT_UV] = battery_undervoltage_flag;
      det_raw[`FWS_I_TSD] = global_thermal_shutdown_flag;
      det_raw[`FWS_I_CH1_TSD] = chan1_thermal_shutdown_flag;
      det_raw[`FWS_I_CH2_TSD] = chan2_thermal_shutdown_flag;
      det_raw[`FWS_I_TWN] = global_thermal_warning_flag;
      det_raw[`FWS_I_CH1_TWN] = chan1_thermal_warning_flag;
      det_raw[`FWS_I_CH2_TWN] = chan2_thermal_warning_flag;
   end

   fws_flag_sync u_sync (
      .clock(clock),
      .reset(reset),
      .det_in(det_raw),
      .det_q(det_s)
   );

   // -----------------------------------------------------------------
   // power-on indication and pin mask
   // -----------------------------------------------------------------
   logic por_q;
   fws_pkg::fws_byte_t mask_q;

   // set by reset, cleared by clear pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         por_q <= 1'b1;
      end else if (por_clear) begin
         por_q <= 1'b0;
      end
   end

   // pin control word, the only writable byte
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mask_q <= `FWS_PINCTL_RST;
      end else if (reg_sel && reg_write && reg_addr == `FWS_ADDR_PINCTL) begin
         mask_q <= reg_wdata;
      end
   end

   // -----------------------------------------------------------------
   // status words
   // -----------------------------------------------------------------
   fws_pkg::fws_byte_t chan_w;
   fws_pkg::fws_byte_t glob1_w;
   fws_pkg::fws_byte_t glob2_w;
   fws_pkg::fws_byte_t warn_w;

   always_comb begin
      chan_w = `FWS_CHAN_RST;
      glob1_w = `FWS_GLOB_RST;
      glob2_w = `FWS_GLOB_RST;
      warn_w = `FWS_ZERO_BYTE;
      chan_w[`FWS_CH1_OVC_BIT] = det_s[`FWS_I_CH1_OVC];
      chan_w[`FWS_CH2_OVC_BIT] = det_s[`FWS_I_CH2_OVC];
      chan_w[`FWS_CH1_OFS_BIT] = det_s[`FWS_I_CH1_OFS];
      chan_w[`FWS_CH2_OFS_BIT] = det_s[`FWS_I_CH2_OFS];
      glob1_w[`FWS_CLK_BIT] = det_s[`FWS_I_CLK];
      glob1_w[`FWS_PS_OV_BIT] = det_s[`FWS_I_PS_OV];
      glob1_w[`FWS_BAT_OV_BIT] = det_s[`FWS_I_BAT_OV];
      glob1_w[`FWS_PS_UV_BIT] = det_s[`FWS_I_PS_UV];
      glob1_w[`FWS_BAT_UV_BIT] = det_s[`FWS_I_BAT_UV];
      glob2_w[`FWS_TSD_BIT] = det_s[`FWS_I_TSD];
      glob2_w[`FWS_CH1_TSD_BIT] = det_s[`FWS_I_CH1_TSD];
      glob2_w[`FWS_CH2_TSD_BIT] = det_s[`FWS_I_CH2_TSD];
      warn_w[`FWS_POR_BIT] = por_q;
      warn_w[`FWS_TWN_BIT] = det_s[`FWS_I_TWN];
      warn_w[`FWS_CH1_TWN_BIT] = det_s[`FWS_I_CH1_TWN];
      warn_w[`FWS_CH2_TWN_BIT] = det_s[`FWS_I_CH2_TWN];
   end

   // -----------------------------------------------------------------
   // register port answer
   // -----------------------------------------------------------------
   fws_pkg::fws_byte_t rdata_d;
   fws_pkg::fws_byte_t rdata_q;
   logic ack_q;

   // read mux, writes and unmapped reads return zero
   always_comb begin
      rdata_d = `FWS_ZERO_BYTE;
      if (reg_sel && !reg_write) begin
         case (reg_addr)
            `FWS_ADDR_CHAN: rdata_d = chan_w;
            `FWS_ADDR_GLOB1: rdata_d = glob1_w;
            `FWS_ADDR_GLOB2: rdata_d = glob2_w;
            `FWS_ADDR_WARN: rdata_d = warn_w;
            `FWS_ADDR_PINCTL: rdata_d = mask_q;
            default: rdata_d = `FWS_ZERO_BYTE;
         endcase
      end
   end

   // answer one cycle after the strobe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rdata_q <= `FWS_ZERO_BYTE;
         ack_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q <= reg_sel;
      end
   end

   // -----------------------------------------------------------------
   // fault and warning pins
   // -----------------------------------------------------------------
   logic fault_d;
   logic warn_d;
   logic fault_q;
   logic warn_q;

   always_comb begin
      fault_d = ((det_s[`FWS_I_CH1_OVC] | det_s[`FWS_I_CH2_OVC]) & ~mask_q[`FWS_MASK_OVC])
         | ((det_s[`FWS_I_TSD] | det_s[`FWS_I_CH1_TSD] | det_s[`FWS_I_CH2_TSD]) & ~mask_q[`FWS_MASK_TSD])
         | ((det_s[`FWS_I_PS_UV] | det_s[`FWS_I_BAT_UV]) & ~mask_q[`FWS_MASK_UV])
         | ((det_s[`FWS_I_PS_OV] | det_s[`FWS_I_BAT_OV]) & ~mask_q[`FWS_MASK_OV])
         | ((det_s[`FWS_I_CH1_OFS] | det_s[`FWS_I_CH2_OFS]) & ~mask_q[`FWS_MASK_OFS]);
      warn_d = (det_s[`FWS_I_TWN] | det_s[`FWS_I_CH1_TWN] | det_s[`FWS_I_CH2_TWN]) & ~mask_q[`FWS_MASK_TWN];
   end

   // pin flops
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         fault_q <= 1'b0;
         warn_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
         warn_q <= warn_d;
      end
   end

   // outputs straight from flops
   assign reg_rdata = rdata_q;
   assign reg_ack = ack_q;
   assign fault_pin = fault_q;
   assign warn_pin = warn_q;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic rd_chan;
   logic rd_glob1;
   logic rd_glob2;
   logic rd_warn;
   assign rd_chan = reg_sel && !reg_write && reg_addr == `FWS_ADDR_CHAN;
   assign rd_glob1 = reg_sel && !reg_write && reg_addr == `FWS_ADDR_GLOB1;
   assign rd_glob2 = reg_sel && !reg_write && reg_addr == `FWS_ADDR_GLOB2;
   assign rd_warn = reg_sel && !reg_write && reg_addr == `FWS_ADDR_WARN;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chan_oc_path_a: assert property (chan1_overcurrent_flag ##1 rd_chan |=> reg_ack && reg_rdata[7])
      else $error("channel 1 overcurrent not reported");
   chan_dc_read_a: assert property (rd_chan |=>
      reg_rdata[3:2] == {$past(det_s[`FWS_I_CH1_OFS]), $past(det_s[`FWS_I_CH2_OFS])}
      && reg_rdata[5:4] == 2'h0 && reg_rdata[1:0] == 2'h0)
      else $error("channel offset field wrong");
   clock_fault_a: assert property (rd_glob1 |=>
      reg_rdata[4] == $past(det_s[`FWS_I_CLK]) && reg_rdata[7:5] == 3'h0)
      else $error("clock fault bit wrong");
   over_volt_a: assert property (battery_overvoltage_flag ##1 rd_glob1 |=> reg_rdata[2])
      else $error("battery overvoltage not reported");
   under_volt_a: assert property (!power_stage_undervoltage_flag ##1 rd_glob1 |=> !reg_rdata[1])
      else $error("power stage undervoltage stuck");
   global_tsd_a: assert property (global_thermal_shutdown_flag ##1 rd_glob2 |=>
      reg_rdata[4] && reg_rdata[1:0] == 2'h0)
      else $error("global shutdown not reported");
   chan_tsd_a: assert property (rd_glob2 |=>
      reg_rdata[3:2] == {$past(det_s[`FWS_I_CH1_TSD]), $past(det_s[`FWS_I_CH2_TSD])})
      else $error("channel shutdown bits wrong");
   por_hold_a: assert property (por_q && !por_clear ##1 rd_warn |=> reg_rdata[5])
      else $error("power-on bit lost");
   global_twarn_a: assert property (global_thermal_warning_flag ##1 rd_warn |=> reg_rdata[4])
      else $error("global warning not reported");
   chan_twarn_a: assert property (rd_warn |=>
      reg_rdata[3:2] == {$past(det_s[`FWS_I_CH1_TWN]), $past(det_s[`FWS_I_CH2_TWN])})
      else $error("channel warning bits wrong");
   // fault words clear out of reset
   fault_reset_a: assert property (disable iff (1'b0) $fell(reset) |->
      chan_w == `FWS_CHAN_RST && glob1_w == `FWS_GLOB_RST && glob2_w == `FWS_GLOB_RST)
      else $error("fault words not clear after reset");
   warn_reset_a: assert property (disable iff (1'b0) $fell(reset) |-> warn_w == `FWS_WARN_RST)
      else $error("warning word reset value wrong");
   fault_pin_a: assert property (det_s[`FWS_I_CH2_OVC] && !mask_q[`FWS_MASK_OVC] |=> fault_pin)
      else $error("fault pin missed overcurrent");
   // full mask keeps fault pin low
   fault_mask_a: assert property (mask_q[7:3] == 5'h1F && $stable(mask_q) |=> !fault_pin)
      else $error("masked fault reached pin");
   warn_pin_a: assert property (det_s[`FWS_I_CH1_TWN] |=> warn_pin == !$past(mask_q[`FWS_MASK_TWN]))
      else $error("warning pin wrong");
   // writes leave the mask alone unless aimed at it
   write_ignore_a: assert property (reg_sel && reg_write && reg_addr != `FWS_ADDR_PINCTL |=>
      $stable(mask_q) && reg_rdata == `FWS_ZERO_BYTE)
      else $error("status write had an effect");

   fault_read_c: cover property (chan1_overcurrent_flag ##1 rd_chan ##1 reg_rdata[7]);
   fault_rise_c: cover property ($rose(fault_pin));
   warn_rise_c: cover property ($rose(warn_pin));
   mask_write_c: cover property (reg_sel && reg_write && reg_addr == `FWS_ADDR_PINCTL);

endmodule : fws_status_bank

// *** hdl/fws_cfg.svh ***
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define FWS_ADDR_CHAN 8'h10
`define FWS_ADDR_GLOB1 8'h11
`define FWS_ADDR_GLOB2 8'h12
`define FWS_ADDR_WARN 8'h13
`define FWS_ADDR_PINCTL 8'h14

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define FWS_CHAN_RST 8'h00
`define FWS_GLOB_RST 8'h00
`define FWS_WARN_RST 8'h20
`define FWS_PINCTL_RST 8'h00
`define FWS_ZERO_BYTE 8'h00

// -----------------------------------------------------------------
// field positions inside the status words
// -----------------------------------------------------------------
`define FWS_CH1_OVC_BIT 7
`define FWS_CH2_OVC_BIT 6
`define FWS_CH1_OFS_BIT 3
`define FWS_CH2_OFS_BIT 2
`define FWS_CLK_BIT 4
`define FWS_PS_OV_BIT 3
`define FWS_BAT_OV_BIT 2
`define FWS_PS_UV_BIT 1
`define FWS_BAT_UV_BIT 0
`define FWS_TSD_BIT 4
`define FWS_CH1_TSD_BIT 3
`define FWS_CH2_TSD_BIT 2
`define FWS_POR_BIT 5
`define FWS_TWN_BIT 4
`define FWS_CH1_TWN_BIT 3
`define FWS_CH2_TWN_BIT 2

// -----------------------------------------------------------------
// mask positions in the pin control word
// -----------------------------------------------------------------
`define FWS_MASK_OVC 7
`define FWS_MASK_TSD 6
`define FWS_MASK_UV 5
`define FWS_MASK_OV 4
`define FWS_MASK_OFS 3
`define FWS_MASK_TWN 0

// -----------------------------------------------------------------
// positions in the registered detector vector
// -----------------------------------------------------------------
`define FWS_NUM_FLAGS 15
`define FWS_I_CH1_OVC 0
`define FWS_I_CH2_OVC 1
`define FWS_I_CH1_OFS 2
`define FWS_I_CH2_OFS 3
`define FWS_I_CLK 4
`define FWS_I_PS_OV 5
`define FWS_I_BAT_OV 6
`define FWS_I_PS_UV 7
`define FWS_I_BAT_UV 8
`define FWS_I_TSD 9
`define FWS_I_CH1_TSD 10
`define FWS_I_CH2_TSD 11
`define FWS_I_TWN 12
`define FWS_I_CH1_TWN 13
`define FWS_I_CH2_TWN 14

`endif

// *** hdl/fws_pkg.sv ***
`include "fws_cfg.svh"

package fws_pkg;
   // one register byte
   typedef logic [7:0] fws_byte_t;
   // registered detector vector
   typedef logic [`FWS_NUM_FLAGS-1:0] fws_flags_t;
endpackage : fws_pkg

// *** hdl/fws_flag_sync.sv ***
`timescale 1ns/1ps
`include "fws_cfg.svh"

module fws_flag_sync (
   input wire logic clock,
   input wire logic reset,
   input wire fws_pkg::fws_flags_t det_in,
   output fws_pkg::fws_flags_t det_q
);

   // -----------------------------------------------------------------
   // one capture flop per detector line
   // -----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `FWS_NUM_FLAGS; gi = gi + 1) begin : g_flag
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               det_q[gi] <= 1'b0;
            end else begin
               det_q[gi] <= det_in[gi];
            end
         end
      end
   endgenerate

endmodule : fws_flag_sync

// *** bench/fws_host_model.sv ***
`timescale 1ns/1ps

module fws_host_model (
   input wire logic clock,
   output logic reg_sel,
   output logic reg_write,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire fws_pkg::fws_byte_t reg_rdata,
   input wire logic reg_ack
);
   // idle request lines at time zero
   initial begin
      reg_sel = 1'b0;
      reg_write = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // one access: a one-cycle strobe, then a bounded wait for the acknowledge
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd,
      output logic [7:0] rd, output logic to);
      to = 1'b1;
      rd = 8'h00;
      reg_sel = 1'b1;
      reg_write = w;
      reg_addr = a;
      reg_wdata = wd;
      @(negedge clock);
      reg_sel = 1'b0;
      // released lines must not keep showing the old value
      reg_write = ~w;
      reg_addr = ~a;
      reg_wdata = ~wd;
      // the answer stands for one cycle right after the strobe, so look before moving on
      for (int i = 0; i < 4 && to; i++) begin
         if (reg_ack === 1'b1) begin
            rd = reg_rdata;
            to = 1'b0;
         end
         @(negedge clock);
      end
   endtask : access
endmodule : fws_host_model

// *** bench/fws_status_bank_tb.sv ***
`timescale 1ns/1ps
`include "fws_cfg.svh"

module fws_status_bank_tb;
   `define CHECK(a, b) begin \
      n_checks++; \
      if ((a) !== (b)) begin \
         n_fail++; \
         $display("MISMATCH t=%0t got %h exp %h", $time, a, b); \
      end \
   end

   logic clock = 1'b0;
   logic reset = 1'b1;
   logic por_clear = 1'b0;
   logic [14:0] det = 15'h0000;
   logic reg_sel, reg_write, reg_ack, fault_pin, warn_pin;
   logic [7:0] reg_addr, reg_wdata;
   fws_pkg::fws_byte_t reg_rdata;
   int n_fail = 0;
   int n_checks = 0;
   // register, bit and mask position of each detector, by vector index
   logic [7:0] addr_t [15] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h11, 8'h11, 8'h11, 8'h11,
      8'h11, 8'h12, 8'h12, 8'h12, 8'h13, 8'h13, 8'h13};
   int bit_t [15] = '{7, 6, 3, 2, 4, 3, 2, 1, 0, 4, 3, 2, 4, 3, 2};
   int mask_t [15] = '{7, 7, 3, 3, -1, 4, 4, 5, 5, 6, 6, 6, 0, 0, 0};

   // 200 MHz clock
   always #2.5 clock = ~clock;

   fws_status_bank DUT (
      .clock(clock), .reset(reset),
      .chan1_overcurrent_flag(det[`FWS_I_CH1_OVC]), .chan2_overcurrent_flag(det[`FWS_I_CH2_OVC]),
      .chan1_offset_fault_flag(det[`FWS_I_CH1_OFS]), .chan2_offset_fault_flag(det[`FWS_I_CH2_OFS]),
      .invalid_clock_flag(det[`FWS_I_CLK]),
      .power_stage_overvoltage_flag(det[`FWS_I_PS_OV]), .battery_overvoltage_flag(det[`FWS_I_BAT_OV]),
      .power_stage_undervoltage_flag(det[`FWS_I_PS_UV]), .battery_undervoltage_flag(det[`FWS_I_BAT_UV]),
      .global_thermal_shutdown_flag(det[`FWS_I_TSD]), .chan1_thermal_shutdown_flag(det[`FWS_I_CH1_TSD]),
      .chan2_thermal_shutdown_flag(det[`FWS_I_CH2_TSD]), .global_thermal_warning_flag(det[`FWS_I_TWN]),
      .chan1_thermal_warning_flag(det[`FWS_I_CH1_TWN]), .chan2_thermal_warning_flag(det[`FWS_I_CH2_TWN]),
      .por_clear(por_clear), .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .fault_pin(fault_pin), .warn_pin(warn_pin)
   );

   fws_host_model host (
      .clock(clock), .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack)
   );

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // verdict and end of run
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // one register access; a missing acknowledge ends the run
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
      logic to;
      host.access(w, a, wd, rd, to);
      if (to) begin
         n_fail++;
         $display("MISMATCH t=%0t no acknowledge", $time);
         finish_test();
      end
   endtask : xfer

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   // reset values, then clearing of the power-on indication
   task automatic t_reset;
      logic [7:0] rd;
      for (int i = 0; i < 3; i++) begin
         xfer(1'b0, 8'h10 + 8'(i), 8'h00, rd);
         `CHECK(rd, 8'h00)
      end
      xfer(1'b0, 8'h13, 8'h00, rd);
      `CHECK(rd, 8'h20)
      por_clear = 1'b1;
      @(negedge clock);
      por_clear = 1'b0;
      xfer(1'b0, 8'h13, 8'h00, rd);
      `CHECK(rd, 8'h00)
   endtask : t_reset

   // each detector alone: its register bit, then its pin with mask open and shut; the clock fault has no pin, so only both pins low
   task automatic t_walk;
      logic [7:0] rd, ex;
      for (int i = 0; i < 15; i++) begin
         ex = 8'h00;
         ex[bit_t[i]] = 1'b1;
         det = 15'h0000;
         det[i] = 1'b1;
         repeat (3) @(negedge clock);
         xfer(1'b0, addr_t[i], 8'h00, rd);
         `CHECK(rd, ex)
         `CHECK(fault_pin, (mask_t[i] > 0))
         `CHECK(warn_pin, (mask_t[i] == 0))
         if (mask_t[i] >= 0) begin
            xfer(1'b1, 8'h14, 8'h01 << mask_t[i], rd);
            repeat (2) @(negedge clock);
            `CHECK({fault_pin, warn_pin}, 2'b00)
            xfer(1'b1, 8'h14, 8'h00, rd);
         end
      end
   endtask : t_walk

   // writes to status words ignored, reserved bits zero, mask reads back
   task automatic t_readonly;
      logic [7:0] rd;
      logic [7:0] full [4] = '{8'hCC, 8'h1F, 8'h1C, 8'h1C};
      det = 15'h0000;
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, 8'h10 + 8'(i), 8'hFF, rd);
         xfer(1'b0, 8'h10 + 8'(i), 8'h00, rd);
         `CHECK(rd, 8'h00)
      end
      det = 15'h7FFF;
      repeat (3) @(negedge clock);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, 8'h10 + 8'(i), 8'h00, rd);
         `CHECK(rd, full[i])
      end
      `CHECK({fault_pin, warn_pin}, 2'b11)
      // every fault mask set at once, warning left open
      xfer(1'b1, 8'h14, 8'hF8, rd);
      repeat (2) @(negedge clock);
      `CHECK({fault_pin, warn_pin}, 2'b01)
      xfer(1'b0, 8'h20, 8'h00, rd);
      `CHECK(rd, 8'h00)
      xfer(1'b1, 8'h14, 8'hA5, rd);
      xfer(1'b0, 8'h14, 8'h00, rd);
      `CHECK(rd, 8'hA5)
   endtask : t_readonly

   // a second reset in mid-run restores the power-on indication
   task automatic t_rereset;
      logic [7:0] rd;
      det = 15'h0000;
      reset = 1'b1;
      repeat (2) @(negedge clock);
      reset = 1'b0;
      xfer(1'b0, 8'h13, 8'h00, rd);
      `CHECK(rd, 8'h20)
      xfer(1'b0, 8'h14, 8'h00, rd);
      `CHECK(rd, 8'h00)
   endtask : t_rereset

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (12) @(negedge clock);
      reset = 1'b0;
      t_reset();
      t_walk();
      t_readonly();
      t_rereset();
      finish_test();
   end
endmodule : fws_status_bank_tb
